// File: dv/tb_top.sv
// self-checking bench for the usb port control block
// assumes the far-end model resolves the pads from the block's outputs
`timescale 1ns/1ps

module tb_top;
  reg         clk_sys = 1'b0; // 125 MHz
  reg         rst = 1'b1;
  reg  [15:0] cpuAddr = 16'h0000, cpuWdata = 16'h0000, hostAddr = 16'h0000, hostWdata = 16'h0000;
  reg         cpuWr = 1'b0, cpuRd = 1'b0, hostWr = 1'b0, hostRd = 1'b0;
  reg  [1:0]  portSelB = 2'h0;
  reg  [1:0]  txDp = 2'h0, txDm = 2'h0, txEn = 2'h0; // engine transmit levels
  reg  [3:0]  farDrive = 4'hf, farDp = 4'hf, farDm = 4'h0; // far end idles in j
  reg  [15:0] q; // last read word
  wire [15:0] cpuRdata, hostRdata;
  wire        cpuRdValid, hostRdValid;
  wire [1:0]  hostRole, suspended;
  wire [3:0]  dpIn, dmIn, lowSpeed, pullUpDp, pullUpDm, pullDownDp, pullDownDm;
  wire [3:0]  dpOut, dmOut, lineOeN, xcvrPowerDown, rxValid, sofGen, eopGen;
  wire [3:0]  rxDp, rxDm; // synchronised line levels
  integer     error_cnt = 0, n_checks = 0, i, p, n;

  always #4 clk_sys = ~clk_sys;

  usb_port_line_control #(.ENGINES(2)) i_usb_port_line_control (
    .clk_sys(clk_sys), .rst(rst), .cpuAddr(cpuAddr), .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuWdata(cpuWdata),
    .cpuRdata(cpuRdata), .cpuRdValid(cpuRdValid), .hostAddr(hostAddr), .hostWr(hostWr), .hostRd(hostRd),
    .hostWdata(hostWdata), .hostRdata(hostRdata), .hostRdValid(hostRdValid), .portSelB(portSelB),
    .txDp(txDp), .txDm(txDm), .txEn(txEn), .hostRole(hostRole), .suspended(suspended), .dpIn(dpIn),
    .dmIn(dmIn), .lowSpeed(lowSpeed), .pullUpDp(pullUpDp), .pullUpDm(pullUpDm), .pullDownDp(pullDownDp),
    .pullDownDm(pullDownDm), .dpOut(dpOut), .dmOut(dmOut), .lineOeN(lineOeN), .xcvrPowerDown(xcvrPowerDown),
    .rxDp(rxDp), .rxDm(rxDm), .rxValid(rxValid), .sofGen(sofGen), .eopGen(eopGen));

  usb_far_end i_usb_far_end (
    .clk_sys(clk_sys), .lineOeN(lineOeN), .dpOut(dpOut), .dmOut(dmOut), .pullUpDp(pullUpDp),
    .pullUpDm(pullUpDm), .pullDownDp(pullDownDp), .pullDownDm(pullDownDm), .farDrive(farDrive),
    .farDp(farDp), .farDm(farDm), .dpIn(dpIn), .dmIn(dmIn));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task summarize;
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input [8*12-1:0] what, input [15:0] seen, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  // both ports get address and data; only the chosen one is strobed
  task wr(input h, input [15:0] a, input [15:0] d);
  begin
    @(posedge clk_sys);
    {cpuAddr, cpuWdata, hostAddr, hostWdata} <= {a, d, a, d};
    {hostWr, cpuWr} <= {h, !h};
    @(posedge clk_sys);
    {hostWr, cpuWr} <= 2'b00;
  end
  endtask

  // read strobe, then a bounded wait for the valid pulse
  task rd(input [8*12-1:0] what, input h, input [15:0] a, input [15:0] exp, input [15:0] mask);
  begin
    @(posedge clk_sys);
    {cpuAddr, hostAddr} <= {a, a};
    {hostRd, cpuRd} <= {h, !h};
    @(posedge clk_sys);
    {hostRd, cpuRd} <= 2'b00;
    #1;
    for (n = 0; (h ? hostRdValid : cpuRdValid) !== 1'b1 && n < 4; n = n + 1)
      @(posedge clk_sys) #1;
    if (n == 4)
    begin
      chk("rd valid", 16'h0000, 16'h0001);
      summarize;
    end
    q = h ? hostRdata : cpuRdata;
    chk(what, q & mask, exp);
  end
  endtask

  task tick(input integer k); // let registered outputs settle
  begin
    repeat (k) @(posedge clk_sys);
    #1;
  end
  endtask

  function [15:0] pull4(input integer k); // {pu d+, pu d-, pd d+, pd d-}
    pull4 = {12'h000, pullUpDp[k], pullUpDm[k], pullDownDp[k], pullDownDm[k]};
  endfunction

  function [15:0] pulls(input on, input host, input low);
    pulls = !on ? 16'h0000 : host ? 16'h0003 : low ? 16'h0004 : 16'h0008;
  endfunction

  function [15:0] jk(input [2:0] c); // forced {d+, d-} as bits 15:14; c[2] is low speed
    jk = {(c[1:0] == 2'b01) ? {~c[2], c[2]} : (c[1:0] == 2'b11) ? {c[2], ~c[2]} : 2'b00, 14'h0000};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    tick(3);
    rd("reset e0", 0, 16'hc08a, 16'ha000, 16'hffff);
    rd("reset e1", 1, 16'hc0aa, 16'ha000, 16'hffff);
    wr(1, 16'hc0aa, 16'h5f80);
    rd("host wr", 0, 16'hc0aa, 16'haf80, 16'hffff);
    rd("engine0", 0, 16'hc08a, 16'ha000, 16'hffff);
    wr(0, 16'hc08c, 16'h0fff);
    rd("unmapped wr", 1, 16'hc08a, 16'ha000, 16'hffff);
    rd("unmapped rd", 1, 16'hc08c, 16'h0000, 16'hffff);
    // pull table on both engines; port b resistors toggle with the case
    for (i = 0; i < 8; i = i + 1)
    begin
      p = 2 * i[2];
      wr(i[2], i[2] ? 16'hc0aa : 16'hc08a, {4'h0, i[0], i[0], i[1], i[0] ^ i[1], 1'b1, 7'h00});
      tick(2);
      chk("pulls a", pull4(p), pulls(1'b1, i[1], i[0]));
      chk("pulls b", pull4(p + 1), pulls(i[0] ^ i[1], i[1], i[0]));
      chk("role speed", {13'h0, hostRole[i[2]], lowSpeed[p +: 2]}, {13'h0, i[1], i[0], i[0]});
    end
    wr(1, 16'hc0aa, 16'h0000);
    farDrive <= 4'h0;
    // every forcing code at both speeds on port b while port a is selected
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(0, 16'hc08a, {4'h0, i[2], 4'h0, i[1:0], 5'h00});
      tick(4);
      chk("drive b", {lineOeN[1], (i[1:0] == 0) ? 2'b00 : {dpOut[1], dmOut[1]}, 13'h0},
          ({i[1:0] == 2'b00, 15'h0000} | (jk(i[2:0]) >> 1)));
      if (i[1:0] != 0)
        rd("status b", 0, 16'hc08a, jk(i[2:0]), 16'hc000);
    end
    wr(0, 16'hc08a, 16'h0000);
    farDrive <= 4'hf;
    tick(3);
    chk("rx sel a", {14'h0, rxValid[1:0]}, 16'h0001);
    @(posedge clk_sys);
    portSelB <= 2'h1;
    tick(2);
    chk("rx sel b", {14'h0, rxValid[1:0]}, 16'h0002);
    // engine 0 transmits; only the selected port b may drive its pair
    @(posedge clk_sys);
    txEn <= 2'h1;
    txDp <= 2'h1;
    txDm <= 2'h2;
    tick(2);
    chk("tx drive", {12'h0, lineOeN[1:0], dpOut[1], dmOut[1]}, 16'h0006);
    wr(0, 16'hc08a, 16'h0004);
    farDp <= 4'he;
    tick(4);
    chk("suspend", {11'h0, lineOeN[1], suspended[0], xcvrPowerDown[1:0], rxValid[1]}, 16'h001e);
    chk("rx lines", {8'h0, rxDp, rxDm}, 16'h00e0);
    rd("wake watch", 0, 16'hc08a, 16'h8004, 16'hffff);
    wr(0, 16'hc08a, 16'h0603);
    farDp <= 4'hf;
    portSelB <= 2'h0;
    tick(2);
    chk("eop a", {12'h0, sofGen[1:0], eopGen[1:0]}, 16'h0001);
    @(posedge clk_sys);
    portSelB <= 2'h1;
    tick(2);
    chk("sof b", {12'h0, sofGen[1:0], eopGen[1:0]}, 16'h0008);
    summarize;
  end
endmodule // tb_top

// File: dv/usb_far_end.sv
// far-end model: the usb devices or hosts attached to the four ports
// assumes the block drives a pair only while its lineOeN is low
`timescale 1ns/1ps

module usb_far_end
(
  input  wire       clk_sys,    // pattern clock for floating lines
  input  wire [3:0] lineOeN,    // block drives when low
  input  wire [3:0] dpOut,      // block d+ level
  input  wire [3:0] dmOut,      // block d- level
  input  wire [3:0] pullUpDp,   // block d+ pull-up
  input  wire [3:0] pullUpDm,   // block d- pull-up
  input  wire [3:0] pullDownDp, // block d+ pull-down
  input  wire [3:0] pullDownDm, // block d- pull-down
  input  wire [3:0] farDrive,   // far end drives the pair
  input  wire [3:0] farDp,      // far end d+
  input  wire [3:0] farDm,      // far end d-
  output reg  [3:0] dpIn,       // resolved d+
  output reg  [3:0] dmIn        // resolved d-
);
  // ----------------------------------------
  // pad resolution
  // ----------------------------------------
  reg     wobble = 1'b0; // a floating line flips so it never reads steady
  integer i;

  always @(posedge clk_sys)
    wobble <= ~wobble;

  // block drive wins, then far drive, then pulls, else floating
  always @*
    for (i = 0; i < 4; i = i + 1)
    begin
      dpIn[i] = !lineOeN[i] ? dpOut[i] : farDrive[i] ? farDp[i] : pullUpDp[i] | (~pullDownDp[i] & wobble);
      dmIn[i] = !lineOeN[i] ? dmOut[i] : farDrive[i] ? farDm[i] : pullUpDm[i] | (~pullDownDm[i] & ~wobble);
    end
endmodule // usb_far_end

// File: dv/usb_port_line_control_sva.sv
// assertions on the usb port control block, watching top-level ports only
// assumes one clk_sys domain and an active-high asynchronous rst
`timescale 1ns/1ps

module usb_port_line_control_sva
#(
  parameter ENGINES = 2 // engines of the bound instance
)
(
  input wire                 clk_sys,
  input wire                 rst,
  input wire [15:0]          cpuAddr,
  input wire                 cpuWr,
  input wire [15:0]          cpuWdata,
  input wire [ENGINES-1:0]   portSelB,
  input wire [ENGINES-1:0]   hostRole,
  input wire [ENGINES-1:0]   suspended,
  input wire [2*ENGINES-1:0] dpIn,
  input wire [2*ENGINES-1:0] lowSpeed,
  input wire [2*ENGINES-1:0] pullUpDp,
  input wire [2*ENGINES-1:0] pullUpDm,
  input wire [2*ENGINES-1:0] pullDownDm,
  input wire [2*ENGINES-1:0] dpOut,
  input wire [2*ENGINES-1:0] dmOut,
  input wire [2*ENGINES-1:0] lineOeN,
  input wire [2*ENGINES-1:0] xcvrPowerDown,
  input wire [2*ENGINES-1:0] rxDp,
  input wire [2*ENGINES-1:0] rxValid,
  input wire [2*ENGINES-1:0] sofGen,
  input wire [2*ENGINES-1:0] eopGen
);
  // ----------------------------------------
  // engine 0 checks, ports 0 (a) and 1 (b), except a_line_sync, which checks d+ of every port
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_role_write:
    assert property (cpuWr && cpuAddr == 16'hc08a |=> hostRole[0] == $past(cpuWdata[9]))
    else $error("engine role does not follow the written value");
  a_host_pulls:
    assert property (pullDownDm[0] |-> $past(hostRole[0]) && !pullUpDp[0] && !pullUpDm[0])
    else $error("pull-down present outside host role");
  a_dev_pullup:
    assert property (pullUpDm[0] |-> $past(lowSpeed[0]) && !$past(hostRole[0]) && !pullUpDp[0])
    else $error("d- pull-up outside low-speed device role");
  a_force_se0:
    assert property (cpuWr && cpuAddr == 16'hc08a && cpuWdata[6:5] == 2'b10
                     |=> ##1 !lineOeN[1] && !dpOut[1] && !dmOut[1])
    else $error("port b not driven to se0");
  a_suspend_power:
    assert property (xcvrPowerDown[1:0] == {2{$past(suspended[0])}})
    else $error("transceiver power does not track suspend");
  a_rx_active:
    assert property (rxValid[1] |-> $past(portSelB[0]) && !$past(suspended[0]))
    else $error("receive live on an unselected or suspended port");
  a_line_sync:
    assert property (!$past(rst) && !$past(rst, 2) |-> rxDp == $past(dpIn, 2))
    else $error("received d+ not two cycles behind the pad");
  a_marker_gate:
    assert property (sofGen[0] || eopGen[0] |-> $past(hostRole[0]) && eopGen[0] == $past(lowSpeed[0]))
    else $error("frame marker enable outside host role or wrong kind");
  c_se0: cover property (!lineOeN[1] && !dpOut[1] && !dmOut[1]);
  c_eop: cover property (eopGen[0]);
  c_pullup: cover property (pullUpDm[0]);
endmodule // usb_port_line_control_sva

bind usb_port_line_control usb_port_line_control_sva #(.ENGINES(ENGINES)) i_usb_port_line_control_sva (
  .clk_sys(clk_sys), .rst(rst), .cpuAddr(cpuAddr), .cpuWr(cpuWr), .cpuWdata(cpuWdata),
  .portSelB(portSelB), .hostRole(hostRole), .suspended(suspended), .dpIn(dpIn), .lowSpeed(lowSpeed),
  .pullUpDp(pullUpDp), .pullUpDm(pullUpDm), .pullDownDm(pullDownDm), .dpOut(dpOut), .dmOut(dmOut),
  .lineOeN(lineOeN), .xcvrPowerDown(xcvrPowerDown), .rxDp(rxDp), .rxValid(rxValid), .sofGen(sofGen),
  .eopGen(eopGen));

// File: rtl/usb_port_ctrl_regs.vh
// register map and field layout of the per-engine usb port control register
// assumes it is included by bare name from the design files under rtl/
`ifndef USB_PORT_CTRL_REGS_VH
`define USB_PORT_CTRL_REGS_VH

// ---------------------------------------------------------------
// register offsets, one control register per serial engine
// ---------------------------------------------------------------
`define ENGINE1_PORT_CONTROL_ADDR 16'hc08a
`define ENGINE2_PORT_CONTROL_ADDR 16'hc0aa

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PB_DP_STATUS_BIT      15
`define PB_DM_STATUS_BIT      14
`define PA_DP_STATUS_BIT      13
`define PA_DM_STATUS_BIT      12
`define PB_LOW_SPEED_BIT      11
`define PA_LOW_SPEED_BIT      10
`define HOST_MODE_BIT         9
`define PB_RESISTORS_BIT      8
`define PA_RESISTORS_BIT      7
`define PB_FORCE_MSB          6
`define PB_FORCE_LSB          5
`define PA_FORCE_MSB          4
`define PA_FORCE_LSB          3
`define SUSPEND_BIT           2
`define PB_FRAME_MARK_BIT     1
`define PA_FRAME_MARK_BIT     0
`define CTRL_WRITABLE_MSB     11

// ---------------------------------------------------------------
// reset values and force-field codes
// ---------------------------------------------------------------
`define CTRL_RESET            12'h000
`define FORCE_NORMAL          2'h0
`define FORCE_SE0             2'h2
`define FORCE_J               2'h1
`define FORCE_K               2'h3

`endif

// File: rtl/usb_port_line.v
// one usb port: line synchroniser, pull resistor steering, line forcing,
// transmit/receive gating and frame-marker enables
// assumes dpIn/dmIn may be asynchronous and all controls come from clk_sys
`timescale 1ns/1ps

module usb_port_line
(
  input  wire       clk_sys,     // system clock
  input  wire       rst,         // async reset, active high
  input  wire       dpIn,        // d+ level from pad
  input  wire       dmIn,        // d- level from pad
  input  wire       lowSpeed,    // speed select of this port
  input  wire       hostMode,    // engine role
  input  wire       resistorsOn, // pull resistor enable of this port
  input  wire [1:0] forceState,  // line forcing code
  input  wire       portActive,  // port select points here
  input  wire       suspend,     // suspend of the engine
  input  wire       frameMarkOn, // frame marker enable of this port
  input  wire       txDp,        // engine transmit d+
  input  wire       txDm,        // engine transmit d-
  input  wire       txEn,        // engine transmit enable
  output reg        dpStatus,    // synchronised d+
  output reg        dmStatus,    // synchronised d-
  output reg        pullUpDp,    // pull-up on d+
  output reg        pullUpDm,    // pull-up on d-
  output reg        pullDownDp,  // pull-down on d+
  output reg        pullDownDm,  // pull-down on d-
  output reg        dpOut,       // d+ drive level
  output reg        dmOut,       // d- drive level
  output reg        lineOeN,     // low while driving both lines
  output reg        xcvrPowerDown, // transceiver power down
  output reg        rxValid,     // received levels are meaningful
  output reg        sofGen,      // start-of-frame generation enabled
  output reg        eopGen       // keep-alive end-of-packet enabled
);
`include "usb_port_ctrl_regs.vh"

  // ---------------------------------------------------------------
  // synchroniser; first stage is read by the second stage only
  // ---------------------------------------------------------------
  reg dpMeta;
  reg dmMeta;

  // two flops per line so status reads are free of metastability
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dpMeta   <= 1'b0;
      dmMeta   <= 1'b0;
      dpStatus <= 1'b0;
      dmStatus <= 1'b0;
    end
    else
    begin
      dpMeta   <= dpIn;
      dmMeta   <= dmIn;
      dpStatus <= dpMeta;
      dmStatus <= dmMeta;
    end
  end

  // ---------------------------------------------------------------
  // line control, all outputs registered
  // ---------------------------------------------------------------
  // j is the idle level: d+ high at full speed, d- high at low speed
  wire jDp = ~lowSpeed;
  wire jDm = lowSpeed;

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pullUpDp      <= 1'b0;
      pullUpDm      <= 1'b0;
      pullDownDp    <= 1'b0;
      pullDownDm    <= 1'b0;
      dpOut         <= 1'b0;
      dmOut         <= 1'b0;
      lineOeN       <= 1'b1;
      xcvrPowerDown <= 1'b0;
      rxValid       <= 1'b0;
      sofGen        <= 1'b0;
      eopGen        <= 1'b0;
    end
    else
    begin
      // pulls stay on in suspend so the lines can still show a wakeup
      pullDownDp <= resistorsOn & hostMode;
      pullDownDm <= resistorsOn & hostMode;
      pullUpDp   <= resistorsOn & ~hostMode & ~lowSpeed;
      pullUpDm   <= resistorsOn & ~hostMode & lowSpeed;
      xcvrPowerDown <= suspend;
      // receive only on the selected port and never in suspend
      rxValid <= portActive & ~suspend;
      // markers only in host role; the speed bit picks which one
      sofGen <= hostMode & frameMarkOn & portActive & ~suspend & ~lowSpeed;
      eopGen <= hostMode & frameMarkOn & portActive & ~suspend & lowSpeed;
      // forcing ignores the port select, so either port can be forced
      case (forceState)
        `FORCE_SE0:
        begin
          dpOut   <= 1'b0;
          dmOut   <= 1'b0;
          lineOeN <= 1'b0;
        end
        `FORCE_J:
        begin
          dpOut   <= jDp;
          dmOut   <= jDm;
          lineOeN <= 1'b0;
        end
        `FORCE_K:
        begin
          dpOut   <= jDm;
          dmOut   <= jDp;
          lineOeN <= 1'b0;
        end
        default:
        begin
          // normal operation: engine drives the active port when awake
          dpOut   <= txDp;
          dmOut   <= txDm;
          lineOeN <= ~(txEn & portActive & ~suspend);
        end
      endcase
    end
  end

endmodule // usb_port_line

// File: rtl/usb_port_line_control.v
// two engines' usb control registers, reachable from the internal processor
// port and the parallel host port, plus four port line controllers
// assumes both access ports are synchronous to clk_sys; pads are async
//
// Notes on behaviour
// - bits 15:12 show live d+/d- of B, A
// - bit 11 set means port B low speed
// - bit 10 set means port A low speed
// - bit 9 set host role, clear device
// - device role serves only the selected port; the code still applies the pull-ups on the unselected port too
// - bit 8 clear disconnects all port B pulls
// - bit 7 clear disconnects all port A pulls
// - host role: pull-downs on both data lines
// - device role: one pull-up, d- if low speed
// - force fields 6:5 B, 4:3 A, ignore select
// - force codes: 00 normal, 10 se0, 01 j, 11 k
// - bit 2 suspends transceivers, keeps line monitoring
// - both processor and parallel host port access registers
// - two identical registers at c08a and c0aa
// - bits 1,0 enable frame markers in host role
`timescale 1ns/1ps

module usb_port_line_control
#(
  parameter ENGINES = 2 // number of serial engines
)
(
  input  wire                    clk_sys,       // system clock, 125 MHz
  input  wire                    rst,           // async reset, active high
  // internal processor register port
  input  wire [15:0]             cpuAddr,       // byte address
  input  wire                    cpuWr,         // write strobe
  input  wire                    cpuRd,         // read strobe
  input  wire [15:0]             cpuWdata,      // write data
  output reg  [15:0]             cpuRdata,      // read data
  output reg                     cpuRdValid,    // read data valid pulse
  // parallel host port register access
  input  wire [15:0]             hostAddr,      // byte address
  input  wire                    hostWr,        // write strobe
  input  wire                    hostRd,        // read strobe
  input  wire [15:0]             hostWdata,     // write data
  output reg  [15:0]             hostRdata,     // read data
  output reg                     hostRdValid,   // read data valid pulse
  // per engine: port select from the host count register, transmit path
  input  wire [ENGINES-1:0]      portSelB,      // 1 selects port B
  input  wire [ENGINES-1:0]      txDp,          // engine transmit d+
  input  wire [ENGINES-1:0]      txDm,          // engine transmit d-
  input  wire [ENGINES-1:0]      txEn,          // engine transmit enable
  output wire [ENGINES-1:0]      hostRole,      // engine in host role
  output wire [ENGINES-1:0]      suspended,     // engine suspended
  // per port, index = engine*2 + (0 for A, 1 for B)
  input  wire [2*ENGINES-1:0]    dpIn,          // d+ pad level
  input  wire [2*ENGINES-1:0]    dmIn,          // d- pad level
  output wire [2*ENGINES-1:0]    lowSpeed,      // port low speed
  output wire [2*ENGINES-1:0]    pullUpDp,      // d+ pull-up on
  output wire [2*ENGINES-1:0]    pullUpDm,      // d- pull-up on
  output wire [2*ENGINES-1:0]    pullDownDp,    // d+ pull-down on
  output wire [2*ENGINES-1:0]    pullDownDm,    // d- pull-down on
  output wire [2*ENGINES-1:0]    dpOut,         // d+ drive level
  output wire [2*ENGINES-1:0]    dmOut,         // d- drive level
  output wire [2*ENGINES-1:0]    lineOeN,       // low while driving
  output wire [2*ENGINES-1:0]    xcvrPowerDown, // transceiver off
  output wire [2*ENGINES-1:0]    rxDp,          // received d+
  output wire [2*ENGINES-1:0]    rxDm,          // received d-
  output wire [2*ENGINES-1:0]    rxValid,       // receive path live
  output wire [2*ENGINES-1:0]    sofGen,        // frame starts enabled
  output wire [2*ENGINES-1:0]    eopGen         // keep-alive markers enabled
);
`include "usb_port_ctrl_regs.vh"

  // ---------------------------------------------------------------
  // storage: writable bits 11:0 per engine, status bits are live
  // ---------------------------------------------------------------
  reg  [11:0]           ctrl [0:ENGINES-1]; // control bits per engine
  wire [2*ENGINES-1:0]  dpStatus;           // synchronised d+ per port
  wire [2*ENGINES-1:0]  dmStatus;           // synchronised d- per port
  wire [15:0]           readWord [0:ENGINES-1]; // assembled read value

  // address of each engine's register; this block only knows two
  function [15:0] engineAddr;
    input integer e;
    begin
      engineAddr = (e == 0) ? `ENGINE1_PORT_CONTROL_ADDR : `ENGINE2_PORT_CONTROL_ADDR;
    end
  endfunction

  genvar e;
  generate
    for (e = 0; e < ENGINES; e = e + 1)
    begin : engine
      wire cpuHit  = (cpuAddr == engineAddr(e));
      wire hostHit = (hostAddr == engineAddr(e));

      // ---------------------------------------------------------------
      // control register write
      // ---------------------------------------------------------------
      // processor wins a same-cycle write clash; host write is dropped
      always @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          ctrl[e] <= `CTRL_RESET;
        else if (cpuWr && cpuHit)
          ctrl[e] <= cpuWdata[`CTRL_WRITABLE_MSB:0];
        else if (hostWr && hostHit)
          ctrl[e] <= hostWdata[`CTRL_WRITABLE_MSB:0];
      end

      // read value: live line status above the writable bits
      assign readWord[e] = {dpStatus[2*e+1], dmStatus[2*e+1],
                            dpStatus[2*e], dmStatus[2*e], ctrl[e]};

      assign hostRole[e]  = ctrl[e][`HOST_MODE_BIT];
      assign suspended[e] = ctrl[e][`SUSPEND_BIT];
      assign lowSpeed[2*e+1] = ctrl[e][`PB_LOW_SPEED_BIT];
      assign lowSpeed[2*e]   = ctrl[e][`PA_LOW_SPEED_BIT];
      assign rxDp[2*e+1:2*e] = dpStatus[2*e+1:2*e];
      assign rxDm[2*e+1:2*e] = dmStatus[2*e+1:2*e];

      // ---------------------------------------------------------------
      // port B line controller
      // ---------------------------------------------------------------
      usb_port_line portB
      (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .dpIn          (dpIn[2*e+1]),
        .dmIn          (dmIn[2*e+1]),
        .lowSpeed      (ctrl[e][`PB_LOW_SPEED_BIT]),
        .hostMode      (ctrl[e][`HOST_MODE_BIT]),
        .resistorsOn   (ctrl[e][`PB_RESISTORS_BIT]),
        .forceState    (ctrl[e][`PB_FORCE_MSB:`PB_FORCE_LSB]),
        .portActive    (portSelB[e]),
        .suspend       (ctrl[e][`SUSPEND_BIT]),
        .frameMarkOn   (ctrl[e][`PB_FRAME_MARK_BIT]),
        .txDp          (txDp[e]),
        .txDm          (txDm[e]),
        .txEn          (txEn[e]),
        .dpStatus      (dpStatus[2*e+1]),
        .dmStatus      (dmStatus[2*e+1]),
        .pullUpDp      (pullUpDp[2*e+1]),
        .pullUpDm      (pullUpDm[2*e+1]),
        .pullDownDp    (pullDownDp[2*e+1]),
        .pullDownDm    (pullDownDm[2*e+1]),
        .dpOut         (dpOut[2*e+1]),
        .dmOut         (dmOut[2*e+1]),
        .lineOeN       (lineOeN[2*e+1]),
        .xcvrPowerDown (xcvrPowerDown[2*e+1]),
        .rxValid       (rxValid[2*e+1]),
        .sofGen        (sofGen[2*e+1]),
        .eopGen        (eopGen[2*e+1])
      );

      // ---------------------------------------------------------------
      // port A line controller
      // ---------------------------------------------------------------
      usb_port_line portA
      (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .dpIn          (dpIn[2*e]),
        .dmIn          (dmIn[2*e]),
        .lowSpeed      (ctrl[e][`PA_LOW_SPEED_BIT]),
        .hostMode      (ctrl[e][`HOST_MODE_BIT]),
        .resistorsOn   (ctrl[e][`PA_RESISTORS_BIT]),
        .forceState    (ctrl[e][`PA_FORCE_MSB:`PA_FORCE_LSB]),
        .portActive    (~portSelB[e]),
        .suspend       (ctrl[e][`SUSPEND_BIT]),
        .frameMarkOn   (ctrl[e][`PA_FRAME_MARK_BIT]),
        .txDp          (txDp[e]),
        .txDm          (txDm[e]),
        .txEn          (txEn[e]),
        .dpStatus      (dpStatus[2*e]),
        .dmStatus      (dmStatus[2*e]),
        .pullUpDp      (pullUpDp[2*e]),
        .pullUpDm      (pullUpDm[2*e]),
        .pullDownDp    (pullDownDp[2*e]),
        .pullDownDm    (pullDownDm[2*e]),
        .dpOut         (dpOut[2*e]),
        .dmOut         (dmOut[2*e]),
        .lineOeN       (lineOeN[2*e]),
        .xcvrPowerDown (xcvrPowerDown[2*e]),
        .rxValid       (rxValid[2*e]),
        .sofGen        (sofGen[2*e]),
        .eopGen        (eopGen[2*e])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // read mux: combinational select, registered data
  // ---------------------------------------------------------------
  reg [15:0] next_cpuRdata;  // word the processor will see
  reg [15:0] next_hostRdata; // word the host port will see
  integer    i;

  // unmapped addresses read as zero rather than stale data
  always @*
  begin
    next_cpuRdata  = 16'h0000;
    next_hostRdata = 16'h0000;
    for (i = 0; i < ENGINES; i = i + 1)
    begin
      if (cpuAddr == engineAddr(i))
        next_cpuRdata = readWord[i];
      if (hostAddr == engineAddr(i))
        next_hostRdata = readWord[i];
    end
  end

  // read data lands one edge after the strobe and holds until next read
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cpuRdata    <= 16'h0000;
      cpuRdValid  <= 1'b0;
      hostRdata   <= 16'h0000;
      hostRdValid <= 1'b0;
    end
    else
    begin
      cpuRdValid  <= cpuRd;
      hostRdValid <= hostRd;
      if (cpuRd)
        cpuRdata <= next_cpuRdata;
      if (hostRd)
        hostRdata <= next_hostRdata;
    end
  end

endmodule // usb_port_line_control
